/* verilog/iapfc_pkg.sv */
// package: register map, field positions, codes and timing for the flash program controller
package iapfc_pkg;
	// register byte offsets on apb
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CHIPRST = 8'h04;
	localparam logic [7:0] OFS_ADDR_LO = 8'h08;
	localparam logic [7:0] OFS_ADDR_HI = 8'h0C;
	localparam logic [7:0] OFS_DATA_BASE = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h30;
	// control register fields
	localparam int BIT_ENABLED = 7;
	localparam int BIT_OPSEL_HI = 6;
	localparam int BIT_OPSEL_LO = 4;
	localparam int BIT_UNLOCK = 3;
	localparam int BIT_WSTART = 2;
	localparam int BIT_RPERMIT = 1;
	localparam int BIT_RSTART = 0;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] CHIP_RESET_KEY = 8'h55;
	localparam logic [3:0] ADDR_HI_MASK = 4'hF;
	// operation codes
	typedef enum logic [2:0] {
		IAPFC_OP_PROGRAM = 3'b000,
		IAPFC_OP_ERASE = 3'b001,
		IAPFC_OP_READ = 3'b011,
		IAPFC_OP_UNLOCK = 3'b110
	} iapfc_op_t;
	// unlock key, pairs one to three
	localparam logic [7:0] KEY_LO1 = 8'h00;
	localparam logic [7:0] KEY_LO2 = 8'h0D;
	localparam logic [7:0] KEY_LO3 = 8'hC3;
	localparam logic [7:0] KEY_HI1 = 8'h04;
	localparam logic [7:0] KEY_HI2 = 8'h09;
	localparam logic [7:0] KEY_HI3 = 8'h40;
	// geometry
	localparam int FLASH_WORDS = 4096;
	localparam int ADDR_W = 12;
	localparam int UNIT_WORDS = 4;
	localparam int BLOCK_WORDS = 256;
	localparam logic [1:0] UNIT_BASE = 2'b00;
	localparam logic [7:0] BLOCK_BASE = 8'h00;
	// timing
	localparam int CLK_MHZ = 25;
	localparam int UNLOCK_WINDOW_US = 64;
	localparam int UNLOCK_CYCLES = UNLOCK_WINDOW_US * CLK_MHZ;
	localparam logic [15:0] UNLOCK_CNT = 16'(UNLOCK_CYCLES);
	localparam logic [15:0] CNT_ONE = 16'h0001;
	localparam logic [15:0] CNT_ZERO = 16'h0000;
endpackage : iapfc_pkg

/* verilog/iapfc_top.sv */
// module: flash program controller with apb registers and internal flash array
`timescale 1ns/1ps
module iapfc_top #(
	parameter logic [15:0] UNLOCK_CYCLES_P = iapfc_pkg::UNLOCK_CNT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic cpu_halt,
	output logic chip_reset_req
);
	typedef enum logic [1:0] {
		IAPFC_IDLE = 2'b00,
		IAPFC_PROG = 2'b01,
		IAPFC_ERASE = 2'b10,
		IAPFC_READ = 2'b11
	} iapfc_state_t;

	logic [15:0] flash_mem [iapfc_pkg::FLASH_WORDS];
	logic enabled_q;
	logic [2:0] opsel_q;
	logic unlock_q;
	logic wstart_q;
	logic rpermit_q;
	logic rstart_q;
	logic [7:0] chiprst_q;
	logic [7:0] addr_lo_q;
	logic [3:0] addr_hi_q;
	logic [7:0] dlo_q [4];
	logic [7:0] dhi_q [4];
	logic [15:0] timer_q;
	iapfc_state_t state_q;
	logic [7:0] step_q;
	logic [31:0] prdata_d;
	logic wr_acc;
	logic rd_acc;
	logic ctrl_wr;
	logic expire;
	logic key_ok;
	logic [11:0] flash_addr;
	logic [7:0] wb;

	// data register index for an offset, 4 means not a data register
	function automatic logic [2:0] data_index(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - iapfc_pkg::OFS_DATA_BASE;
		if (a >= iapfc_pkg::OFS_DATA_BASE && rel < 8'h20 && rel[1:0] == 2'b00) begin
			data_index = {1'b0, rel[4:3]};
		end else begin
			data_index = 3'h4;
		end
	endfunction : data_index

	function automatic logic data_is_high(input logic [7:0] a);
		logic [7:0] rel;
		rel = a - iapfc_pkg::OFS_DATA_BASE;
		data_is_high = rel[2];
	endfunction : data_is_high

	assign wr_acc = psel && penable && pwrite;
	assign rd_acc = psel && penable && !pwrite;
	assign wb = pwdata[7:0];
	assign ctrl_wr = wr_acc && paddr == iapfc_pkg::OFS_CTRL;
	assign expire = unlock_q && timer_q == iapfc_pkg::CNT_ONE;
	assign key_ok = dlo_q[1] == iapfc_pkg::KEY_LO1 && dlo_q[2] == iapfc_pkg::KEY_LO2 &&
		dlo_q[3] == iapfc_pkg::KEY_LO3 && dhi_q[1] == iapfc_pkg::KEY_HI1 &&
		dhi_q[2] == iapfc_pkg::KEY_HI2 && dhi_q[3] == iapfc_pkg::KEY_HI3;
	assign flash_addr = {addr_hi_q, addr_lo_q};

	// apb answers every access in its first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= prdata_d;
		end
	end

	always_comb begin
		prdata_d = 32'h0000_0000;
		if (psel && !penable && !pwrite) begin
			unique case (paddr)
				iapfc_pkg::OFS_CTRL: prdata_d[7:0] = {enabled_q, opsel_q, unlock_q, wstart_q, rpermit_q, rstart_q};
				iapfc_pkg::OFS_CHIPRST: prdata_d[7:0] = chiprst_q;
				iapfc_pkg::OFS_ADDR_LO: prdata_d[7:0] = addr_lo_q;
				iapfc_pkg::OFS_ADDR_HI: prdata_d[3:0] = addr_hi_q;
				iapfc_pkg::OFS_STATUS: prdata_d[1:0] = state_q;
				default: begin
					if (data_index(paddr) != 3'h4) begin
						prdata_d[7:0] = data_is_high(paddr) ? dhi_q[data_index(paddr)[1:0]]
							: dlo_q[data_index(paddr)[1:0]];
					end
				end
			endcase
		end
	end

	// the sampled penable cycle is the access edge; pready is high then
	logic take_wr;
	assign take_wr = wr_acc && pready;

	// control register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enabled_q <= 1'b0;
			opsel_q <= 3'b000;
			unlock_q <= 1'b0;
			rpermit_q <= 1'b0;
		end else begin
			if (take_wr && paddr == iapfc_pkg::OFS_CTRL) begin
				opsel_q <= wb[iapfc_pkg::BIT_OPSEL_HI:iapfc_pkg::BIT_OPSEL_LO];
				rpermit_q <= wb[iapfc_pkg::BIT_RPERMIT];
				if (!wb[iapfc_pkg::BIT_ENABLED]) begin
					enabled_q <= 1'b0;
				end
				if (wb[iapfc_pkg::BIT_UNLOCK]) begin
					unlock_q <= 1'b1;
				end
			end
			if (expire) begin
				unlock_q <= 1'b0;
				if (key_ok && opsel_q == iapfc_pkg::IAPFC_OP_UNLOCK) begin
					enabled_q <= 1'b1;
				end
			end
		end
	end

	// unlock window timer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_q <= iapfc_pkg::CNT_ZERO;
		end else if (take_wr && paddr == iapfc_pkg::OFS_CTRL && wb[iapfc_pkg::BIT_UNLOCK] && !unlock_q) begin
			timer_q <= UNLOCK_CYCLES_P;
		end else if (timer_q != iapfc_pkg::CNT_ZERO) begin
			timer_q <= timer_q - iapfc_pkg::CNT_ONE;
		end
	end

	// address and chip reset registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			addr_lo_q <= iapfc_pkg::RESET_BYTE;
			addr_hi_q <= 4'h0;
			chiprst_q <= iapfc_pkg::RESET_BYTE;
			chip_reset_req <= 1'b0;
		end else begin
			chip_reset_req <= 1'b0;
			if (take_wr && paddr == iapfc_pkg::OFS_ADDR_LO) begin
				addr_lo_q <= wb;
			end
			if (take_wr && paddr == iapfc_pkg::OFS_ADDR_HI) begin
				addr_hi_q <= wb[3:0] & iapfc_pkg::ADDR_HI_MASK;
			end
			if (take_wr && paddr == iapfc_pkg::OFS_CHIPRST) begin
				chiprst_q <= wb;
				chip_reset_req <= wb == iapfc_pkg::CHIP_RESET_KEY;
			end
		end
	end

	// staging data pairs, pair zero also takes read results
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < iapfc_pkg::UNIT_WORDS; i++) begin
				dlo_q[i] <= iapfc_pkg::RESET_BYTE;
				dhi_q[i] <= iapfc_pkg::RESET_BYTE;
			end
		end else begin
			if (take_wr && data_index(paddr) != 3'h4 && (enabled_q || unlock_q)) begin
				if (data_is_high(paddr)) begin
					dhi_q[data_index(paddr)[1:0]] <= wb;
				end else begin
					dlo_q[data_index(paddr)[1:0]] <= wb;
				end
			end
			if (state_q == IAPFC_READ) begin
				dlo_q[0] <= flash_mem[flash_addr][7:0];
				dhi_q[0] <= flash_mem[flash_addr][15:8];
			end
		end
	end

	// operation sequencer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_q <= IAPFC_IDLE;
			wstart_q <= 1'b0;
			rstart_q <= 1'b0;
			step_q <= 8'h00;
			cpu_halt <= 1'b0;
		end else begin
			unique case (state_q)
				IAPFC_IDLE: begin
					step_q <= 8'h00;
					if (take_wr && paddr == iapfc_pkg::OFS_CTRL && wb[iapfc_pkg::BIT_WSTART]) begin
						if (enabled_q && wb[iapfc_pkg::BIT_ENABLED] && wb[6:4] == iapfc_pkg::IAPFC_OP_PROGRAM) begin
							wstart_q <= 1'b1;
							cpu_halt <= 1'b1;
							state_q <= IAPFC_PROG;
						end else if (enabled_q && wb[iapfc_pkg::BIT_ENABLED] && wb[6:4] == iapfc_pkg::IAPFC_OP_ERASE) begin
							wstart_q <= 1'b1;
							cpu_halt <= 1'b1;
							state_q <= IAPFC_ERASE;
						end else begin
							wstart_q <= 1'b0;
						end
					end else if (take_wr && paddr == iapfc_pkg::OFS_CTRL && wb[iapfc_pkg::BIT_RSTART]) begin
						if (wb[iapfc_pkg::BIT_RPERMIT] && wb[6:4] == iapfc_pkg::IAPFC_OP_READ) begin
							rstart_q <= 1'b1;
							cpu_halt <= 1'b1;
							state_q <= IAPFC_READ;
						end else begin
							rstart_q <= 1'b0;
						end
					end
				end
				IAPFC_PROG: begin
					step_q <= step_q + 8'h01;
					if (step_q == 8'(iapfc_pkg::UNIT_WORDS - 1)) begin
						wstart_q <= 1'b0;
						cpu_halt <= 1'b0;
						state_q <= IAPFC_IDLE;
					end
				end
				IAPFC_ERASE: begin
					step_q <= step_q + 8'h01;
					if (step_q == 8'(iapfc_pkg::BLOCK_WORDS - 1)) begin
						wstart_q <= 1'b0;
						cpu_halt <= 1'b0;
						state_q <= IAPFC_IDLE;
					end
				end
				IAPFC_READ: begin
					rstart_q <= 1'b0;
					cpu_halt <= 1'b0;
					state_q <= IAPFC_IDLE;
				end
			endcase
		end
	end

	// flash array: one word per cycle while programming or erasing
	always_ff @(posedge pclk) begin
		if (state_q == IAPFC_PROG) begin
			flash_mem[{addr_hi_q, addr_lo_q[7:2], step_q[1:0]}] <= {dhi_q[step_q[1:0]], dlo_q[step_q[1:0]]};
		end else if (state_q == IAPFC_ERASE) begin
			flash_mem[{addr_hi_q, step_q}] <= 16'h0000;
		end
	end
endmodule : iapfc_top

/* dv/iapfc_asserts.sv */
// port checker for the flash program controller
`timescale 1ns/1ps
module iapfc_asserts #(
	parameter logic [15:0] UNLOCK_CYCLES_P = iapfc_pkg::UNLOCK_CNT
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic cpu_halt,
	input wire logic chip_reset_req
);
	logic acc;
	logic [8:0] halt_cnt_q;
	assign acc = psel && penable && pready;
	// length of the current halt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			halt_cnt_q <= 9'h000;
		end else begin
			halt_cnt_q <= cpu_halt ? halt_cnt_q + 9'h001 : 9'h000;
		end
	end
	default clocking @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	sequence s_rd_ctrl;
		acc && pwrite && paddr == iapfc_pkg::OFS_CTRL && pwdata[6:4] == 3'h3;
	endsequence
	sequence s_key_wr;
		acc && pwrite && paddr == iapfc_pkg::OFS_CHIPRST && pwdata[7:0] == iapfc_pkg::CHIP_RESET_KEY;
	endsequence
	AST_RDY:
		assert property (psel && !penable |=> pready ##1 !pready) else $error("access phase not one cycle");
	AST_RDY_IDLE:
		assert property (pready |-> psel && penable) else $error("ready outside access phase");
	AST_RST_PULSE:
		assert property (s_key_wr |=> chip_reset_req ##1 !chip_reset_req) else $error("no chip reset pulse");
	AST_RST_CAUSE:
		assert property (chip_reset_req |-> $past(acc && pwrite && paddr == iapfc_pkg::OFS_CHIPRST
			&& pwdata[7:0] == iapfc_pkg::CHIP_RESET_KEY)) else $error("chip reset without key");
	AST_ADDR_HI:
		assert property (acc && !pwrite && paddr == iapfc_pkg::OFS_ADDR_HI |-> prdata[31:4] == 28'h0)
			else $error("high address upper bits set");
	AST_RD_GO:
		assert property (s_rd_ctrl ##0 pwdata[2:0] == 3'h3 |-> ##[1:2] cpu_halt) else $error("read did not halt");
	AST_RD_DENY:
		assert property (s_rd_ctrl ##0 pwdata[2:0] == 3'h1 |=> !cpu_halt [*2]) else $error("read ran unpermitted");
	AST_HALT_LEN:
		assert property ($fell(cpu_halt) |-> halt_cnt_q inside {9'h001, 9'h004, 9'h100})
			else $error("halt length wrong");
endmodule : iapfc_asserts
bind iapfc_top iapfc_asserts #(.UNLOCK_CYCLES_P(UNLOCK_CYCLES_P)) i_chk (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .cpu_halt(cpu_halt), .chip_reset_req(chip_reset_req));

/* dv/iapfc_flash_ref.sv */
// reference contents of the flash array
`timescale 1ns/1ps
module iapfc_flash_ref;
	logic [15:0] mem [0:4095];
	task automatic erase_blk(input logic [3:0] blk);
		for (int i = 0; i < iapfc_pkg::BLOCK_WORDS; i++) mem[{blk, 8'(i)}] = 16'h0000;
	endtask : erase_blk
	task automatic prog_unit(input logic [11:0] fa, input logic [15:0] w [4]);
		for (int i = 0; i < iapfc_pkg::UNIT_WORDS; i++) mem[{fa[11:2], 2'(i)}] = w[i];
	endtask : prog_unit
endmodule : iapfc_flash_ref

/* dv/tb.sv */
// self-checking testbench for the flash program controller
`timescale 1ns/1ps
module tb;
	localparam logic [7:0] CTL = iapfc_pkg::OFS_CTRL;
	localparam logic [7:0] DAT = iapfc_pkg::OFS_DATA_BASE;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cpu_halt, chip_reset_req;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] wv [4];
	int n_mismatch = 0;
	int compares = 0;
	int n_crst = 0;
	iapfc_top #(.UNLOCK_CYCLES_P(16'h0028)) i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.cpu_halt(cpu_halt), .chip_reset_req(chip_reset_req));
	iapfc_flash_ref i_ref ();
	initial begin
		pclk = 1'h0;
		forever #20 pclk = ~pclk;
	end
	always @(posedge pclk) if (chip_reset_req === 1'h1) n_crst++;
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'h1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'h1 && k < 50);
		r = prdata;
		chk("pslverr", 32'h0, {31'h0, pslverr});
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic rc(input logic [7:0] a, input logic [31:0] e, input string n);
		apb(1'h0, a, 8'h00);
		chk(n, e, r);
	endtask : rc
	task automatic wait_done();
		logic seen;
		seen = 1'h0;
		for (int i = 0; i < 400; i++) begin
			@(posedge pclk);
			if (cpu_halt === 1'h1) seen = 1'h1;
			else if (seen) break;
		end
		chk("halt", 32'h1, {31'h0, seen});
	endtask : wait_done
	task automatic fread(input logic [11:0] fa, input logic [7:0] c);
		logic [7:0] lo;
		apb(1'h1, iapfc_pkg::OFS_ADDR_HI, {4'h0, fa[11:8]});
		apb(1'h1, iapfc_pkg::OFS_ADDR_LO, fa[7:0]);
		apb(1'h1, CTL, c);
		wait_done();
		rc(CTL, {24'h0, c & 8'hFE}, "ctrl");
		apb(1'h0, DAT, 8'h00);
		lo = r[7:0];
		apb(1'h0, DAT + 8'h04, 8'h00);
		chk("word", {16'h0, i_ref.mem[fa]}, {16'h0, r[7:0], lo});
	endtask : fread
	task automatic unlock(input logic [7:0] last);
		logic [7:0] kv [6];
		kv = '{iapfc_pkg::KEY_LO1, iapfc_pkg::KEY_HI1, iapfc_pkg::KEY_LO2, iapfc_pkg::KEY_HI2, iapfc_pkg::KEY_LO3, last};
		apb(1'h1, CTL, 8'h68);
		for (int i = 0; i < 6; i++) apb(1'h1, 8'(DAT + 8 + 4 * i), kv[i]);
		for (int i = 0; i < 40; i++) begin
			apb(1'h0, CTL, 8'h00);
			if (r[3] === 1'h0) break;
		end
		chk("trigger", 32'h0, {31'h0, r[3]});
	endtask : unlock
	task automatic stop_test();
		$display("compares %0d mismatches %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : stop_test
	initial begin
		#400000;
		n_mismatch++;
		stop_test();
	end
	initial begin
		presetn = 1'h0;
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		repeat (10) @(posedge pclk);
		presetn <= 1'h1;
		rc(CTL, 32'h0, "ctrl");
		rc(8'h40, 32'h0, "unmapped");
		apb(1'h1, iapfc_pkg::OFS_ADDR_HI, 8'hFF);
		rc(iapfc_pkg::OFS_ADDR_HI, 32'h0F, "addr_hi");
		apb(1'h1, DAT, 8'hAB);
		rc(DAT, 32'h0, "data0");
		apb(1'h1, CTL, 8'h80);
		rc(CTL, 32'h0, "ctrl");
		$display("test access done");
		unlock(8'h41);
		chk("enabled", 32'h0, {31'h0, r[7]});
		unlock(iapfc_pkg::KEY_HI3);
		chk("enabled", 32'h1, {31'h0, r[7]});
		$display("test unlock done");
		apb(1'h1, iapfc_pkg::OFS_ADDR_HI, 8'h03);
		apb(1'h1, iapfc_pkg::OFS_ADDR_LO, 8'h57);
		apb(1'h1, CTL, 8'h94);
		i_ref.erase_blk(4'h3);
		wait_done();
		rc(CTL, 32'h90, "ctrl");
		fread(12'h300, 8'hB3);
		fread(12'h3FF, 8'hB3);
		for (int j = 0; j < 8; j++) begin
			wv[j / 2][8 * (j % 2) +: 8] = 8'(8'h3C + 8'h11 * j);
			apb(1'h1, 8'(DAT + 4 * j), 8'(8'h3C + 8'h11 * j));
		end
		apb(1'h1, iapfc_pkg::OFS_ADDR_LO, 8'h57);
		apb(1'h1, CTL, 8'h84);
		i_ref.prog_unit(12'h357, wv);
		wait_done();
		rc(CTL, 32'h80, "ctrl");
		for (int j = 0; j < 5; j++) fread(12'(12'h354 + j), 8'hB3);
		$display("test erase_program done");
		apb(1'h1, iapfc_pkg::OFS_ADDR_LO, 8'h54);
		apb(1'h1, CTL, 8'hB1);
		rc(DAT, 32'h0, "data0");
		apb(1'h1, CTL, 8'h00);
		rc(CTL, 32'h0, "ctrl");
		apb(1'h1, CTL, 8'h04);
		rc(CTL, 32'h0, "ctrl");
		fread(12'h354, 8'h33);
		$display("test locked done");
		apb(1'h1, iapfc_pkg::OFS_CHIPRST, 8'h54);
		apb(1'h1, iapfc_pkg::OFS_CHIPRST, 8'h55);
		repeat (2) @(posedge pclk);
		chk("chip_reset", 32'h1, 32'(n_crst));
		$display("test chip_reset done");
		stop_test();
	end
endmodule : tb
